// >>> hw/ssgr_defs.svh
// Constants for the servo stop sequencer and gear ratio block.
// Assumes a single 50 MHz control clock.
`ifndef SSGR_DEFS_SVH
`define SSGR_DEFS_SVH
`define SSGR_CLK_HZ 50000000
`define SSGR_MS_PER_S 1000
`define SSGR_SEL_PPR 4'h0
`define SSGR_SEL_ENC 4'h1
`define SSGR_SEL_NUM 4'h2
`define SSGR_SEL_DEN 4'h3
`define SSGR_SEL_FEED 4'h4
`define SSGR_SEL_DISCFG 4'h5
`define SSGR_SEL_ALMCFG 4'h6
`define SSGR_SEL_BRKTQ 4'h7
`define SSGR_SEL_TOUT 4'h8
`define SSGR_SEL_LOWVEL 4'h9
`define SSGR_SEL_STATUS 4'ha
`define SSGR_PPR_MAX 32'h00800000
`define SSGR_OBJ_MIN 32'h00000001
`define SSGR_OBJ_MAX 32'h7fffffff
`define SSGR_ENC_RES 32'h00800000
`define SSGR_PPR_RST 32'h00000000
`define SSGR_NUM_RST 32'h00000001
`define SSGR_DEN_RST 32'h00000001
`define SSGR_FEED_RST 32'h00002710
`define SSGR_ENC_DIV 64'h0000000000001f40
`define SSGR_CFG_RST 4'h0
`define SSGR_METH_TORQUE 2'h0
`define SSGR_METH_FREE 2'h1
`define SSGR_METH_DYN 2'h2
`define SSGR_POST_FREE 2'h0
`define SSGR_POST_DYN 2'h1
`define SSGR_POST_HOLD 2'h2
`endif

// >>> hw/ssgr_pkg.sv
// Types for the servo stop sequencer and gear ratio block.
// Constants live in ssgr_defs.svh.
package ssgr_pkg;
  typedef enum logic [1:0] {
    SSGR_OFF, SSGR_RUN, SSGR_DECEL, SSGR_POST
  } ssgr_state_t;

  typedef struct packed {
    logic motor_power;
    logic reverse_torque;
    logic dyn_brake;
    logic brake_release;
    logic brake_apply;
  } ssgr_drive_t;

  typedef struct packed {
    logic [31:0] num;
    logic [31:0] den;
    logic from_ppr;
  } ssgr_gear_t;

  typedef struct packed {
    logic [1:0] method;
    logic [1:0] post;
  } ssgr_stopcfg_t;
endpackage : ssgr_pkg

// >>> hw/ssgr_top.sv
// Servo stop sequencer with brake outputs and electronic gear ratio.
// Assumes enable and alarm come from pins; velocity and config port share clk_sys.
`timescale 1ns/1ps
`include "ssgr_defs.svh"

module ssgr_top
  import ssgr_pkg::*;
#(
  parameter int MS_CYCLES = `SSGR_CLK_HZ / `SSGR_MS_PER_S,
  parameter logic [31:0] ENC_COUNTS = `SSGR_ENC_RES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic enable_req,
  input wire logic alarm_in,
  input wire logic restart,
  input wire logic signed [31:0] motor_velocity,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_sel,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_rd_sel,
  output logic [31:0] cfg_rdata,
  output logic servo_enabled_status,
  output logic cmd_accept,
  output logic stopping,
  output ssgr_drive_t drive,
  output logic [15:0] torque_limit,
  output ssgr_gear_t gear,
  output logic ppr_too_low
);

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic al_s1;
    logic al_s2;
    ssgr_state_t st;
    ssgr_stopcfg_t act;
    logic alarm_stop;
    logic [15:0] div;
    logic [15:0] ms_cnt;
    logic [31:0] ppr_pend;
    logic [31:0] ppr_act;
    logic [31:0] enc;
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] feed;
    ssgr_stopcfg_t dis_cfg;
    ssgr_stopcfg_t alm_cfg;
    logic [15:0] brk_tq;
    logic [15:0] tout;
    logic [31:0] low_vel;
    logic [31:0] rdata;
    logic status;
    logic accept;
    ssgr_drive_t drv;
    logic [15:0] tq;
    ssgr_gear_t gr;
    logic ppr_low;
    logic stop;
  } ssgr_regs_t;

  ssgr_regs_t r;
  ssgr_regs_t next_r;

  localparam logic [15:0] DIV_LAST = 16'(MS_CYCLES - 1);

  function automatic logic ssgr_obj_ok(input logic [31:0] v);
    return (v >= `SSGR_OBJ_MIN) && (v <= `SSGR_OBJ_MAX);
  endfunction : ssgr_obj_ok

  function automatic logic [31:0] ssgr_abs(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction : ssgr_abs

  logic en_ok;
  logic al_on;
  logic tick;
  logic decel_done;
  logic [31:0] vel_abs;

  always_comb begin
    next_r = r;
    en_ok = r.en_s2;
    al_on = r.al_s2;
    vel_abs = ssgr_abs(motor_velocity);
    tick = (r.div == DIV_LAST);
    decel_done = 1'b0;

    next_r.en_s1 = enable_req;
    next_r.en_s2 = r.en_s1;
    next_r.al_s1 = alarm_in;
    next_r.al_s2 = r.al_s1;

    // Out-of-range writes are dropped, the old value stays
    if (cfg_wr) begin
      unique case (cfg_sel)
        `SSGR_SEL_PPR: begin
          if (cfg_wdata <= `SSGR_PPR_MAX) begin
            next_r.ppr_pend = cfg_wdata;
          end
        end
        `SSGR_SEL_NUM: begin
          if (ssgr_obj_ok(cfg_wdata)) begin
            next_r.num = cfg_wdata;
          end
        end
        `SSGR_SEL_DEN: begin
          if (ssgr_obj_ok(cfg_wdata)) begin
            next_r.den = cfg_wdata;
          end
        end
        `SSGR_SEL_FEED: begin
          if (ssgr_obj_ok(cfg_wdata)) begin
            next_r.feed = cfg_wdata;
          end
        end
        `SSGR_SEL_DISCFG: begin
          next_r.dis_cfg = cfg_wdata[3:0];
        end
        `SSGR_SEL_ALMCFG: begin
          next_r.alm_cfg = cfg_wdata[3:0];
        end
        `SSGR_SEL_BRKTQ: begin
          next_r.brk_tq = cfg_wdata[15:0];
        end
        `SSGR_SEL_TOUT: begin
          next_r.tout = cfg_wdata[15:0];
        end
        `SSGR_SEL_LOWVEL: begin
          next_r.low_vel = cfg_wdata;
        end
        default: ;
      endcase
    end

    // Pending value only becomes active on restart
    if (restart) begin
      next_r.ppr_act = r.ppr_pend;
    end

    // Millisecond enable for the stop timeout
    next_r.div = tick ? 16'h0000 : r.div + 16'h0001;

    unique case (r.st)
      SSGR_OFF: begin
        if (en_ok && !al_on) begin
          next_r.st = SSGR_RUN;
        end
      end
      SSGR_RUN: begin
        // Alarm outranks a disable seen in the same cycle
        if (al_on) begin
          next_r.st = SSGR_DECEL;
          next_r.act = r.alm_cfg;
          next_r.alarm_stop = 1'b1;
          next_r.ms_cnt = 16'h0000;
          next_r.div = 16'h0000;
        end else if (!en_ok) begin
          next_r.st = SSGR_DECEL;
          next_r.act = r.dis_cfg;
          next_r.alarm_stop = 1'b0;
          next_r.ms_cnt = 16'h0000;
          next_r.div = 16'h0000;
        end
      end
      SSGR_DECEL: begin
        if (tick && r.ms_cnt != 16'hffff) begin
          next_r.ms_cnt = r.ms_cnt + 16'h0001;
        end
        decel_done = (r.ms_cnt >= r.tout) || (vel_abs < r.low_vel);
        if (decel_done) begin
          next_r.st = SSGR_POST;
        end
      end
      SSGR_POST: begin
        if (en_ok && !al_on) begin
          next_r.st = SSGR_RUN;
        end
      end
    endcase

    // Outputs follow the state being entered so they come from flops
    next_r.drv = '0;
    next_r.tq = 16'h0000;
    next_r.status = 1'b0;
    next_r.accept = 1'b0;
    unique case (next_r.st)
      SSGR_OFF: begin
        next_r.drv.brake_apply = 1'b1;
      end
      SSGR_RUN: begin
        next_r.drv.motor_power = 1'b1;
        next_r.drv.brake_release = 1'b1;
        next_r.status = 1'b1;
        next_r.accept = r.status;
      end
      SSGR_DECEL: begin
        // Brake stays released while the motor still turns
        next_r.drv.brake_release = 1'b1;
        unique case (next_r.act.method)
          `SSGR_METH_TORQUE: begin
            next_r.drv.motor_power = 1'b1;
            next_r.drv.reverse_torque = 1'b1;
            next_r.tq = r.brk_tq;
          end
          `SSGR_METH_DYN: begin
            next_r.drv.dyn_brake = 1'b1;
          end
          default: ;
        endcase
      end
      SSGR_POST: begin
        // Motor power stays off in every post state
        unique case (next_r.act.post)
          `SSGR_POST_DYN: begin
            next_r.drv.dyn_brake = 1'b1;
          end
          `SSGR_POST_HOLD: begin
            next_r.drv.dyn_brake = 1'b0;
          end
          default: begin
            next_r.drv.dyn_brake = 1'b0;
          end
        endcase
        next_r.drv.brake_release = 1'b0;
      end
    endcase
    next_r.drv.brake_apply = !next_r.drv.brake_release;
    next_r.stop = (next_r.st == SSGR_DECEL);

    // Gear selection; pulses per rev wins over the objects
    if (r.ppr_act != 32'h00000000) begin
      next_r.gr.num = r.enc;
      next_r.gr.den = r.ppr_act;
      next_r.gr.from_ppr = 1'b1;
    end else if (r.feed != r.enc) begin
      next_r.gr.num = r.enc;
      next_r.gr.den = r.feed;
      next_r.gr.from_ppr = 1'b0;
    end else begin
      next_r.gr.num = r.num;
      next_r.gr.den = r.feed;
      next_r.gr.from_ppr = 1'b0;
    end
    // Flags a host setting too coarse for the encoder; not enforced
    next_r.ppr_low = (r.ppr_act != 32'h00000000) &&
                     ((64'(r.ppr_act) * `SSGR_ENC_DIV) < 64'(r.enc));

    unique case (cfg_rd_sel)
      `SSGR_SEL_PPR: begin
        next_r.rdata = r.ppr_pend;
      end
      `SSGR_SEL_ENC: begin
        next_r.rdata = r.enc;
      end
      `SSGR_SEL_NUM: begin
        next_r.rdata = r.num;
      end
      `SSGR_SEL_DEN: begin
        next_r.rdata = r.den;
      end
      `SSGR_SEL_FEED: begin
        next_r.rdata = r.feed;
      end
      `SSGR_SEL_DISCFG: begin
        next_r.rdata = {28'h0000000, r.dis_cfg};
      end
      `SSGR_SEL_ALMCFG: begin
        next_r.rdata = {28'h0000000, r.alm_cfg};
      end
      `SSGR_SEL_BRKTQ: begin
        next_r.rdata = {16'h0000, r.brk_tq};
      end
      `SSGR_SEL_TOUT: begin
        next_r.rdata = {16'h0000, r.tout};
      end
      `SSGR_SEL_LOWVEL: begin
        next_r.rdata = r.low_vel;
      end
      `SSGR_SEL_STATUS: begin
        next_r.rdata = {24'h000000, r.ppr_low, r.alarm_stop, r.act,
                        r.st};
      end
      default: next_r.rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= SSGR_OFF;
      r.ppr_pend <= `SSGR_PPR_RST;
      r.ppr_act <= `SSGR_PPR_RST;
      r.enc <= ENC_COUNTS;
      r.num <= `SSGR_NUM_RST;
      r.den <= `SSGR_DEN_RST;
      r.feed <= `SSGR_FEED_RST;
      r.dis_cfg <= `SSGR_CFG_RST;
      r.alm_cfg <= `SSGR_CFG_RST;
      r.act <= `SSGR_CFG_RST;
      r.drv.brake_apply <= 1'b1;
      r.gr.den <= `SSGR_FEED_RST;
    end else begin
      r <= next_r;
    end
  end

  assign cfg_rdata = r.rdata;
  assign servo_enabled_status = r.status;
  assign cmd_accept = r.accept;
  assign stopping = r.stop;
  assign drive = r.drv;
  assign torque_limit = r.tq;
  assign gear = r.gr;
  assign ppr_too_low = r.ppr_low;

endmodule : ssgr_top

// >>> dv/ssgr_assertions.sv
// Assertions on the ssgr_top output ports.
// Assumes one clock domain and an async active-high reset.
`timescale 1ns/1ps
module ssgr_assertions
  import ssgr_pkg::*;
#(parameter logic [31:0] ENC_COUNTS = 32'h00800000) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic servo_enabled_status,
  input wire logic cmd_accept,
  input wire logic stopping,
  input wire ssgr_drive_t drive,
  input wire logic [15:0] torque_limit,
  input wire ssgr_gear_t gear,
  input wire logic ppr_too_low
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence accept_late;
    !cmd_accept ##1 cmd_accept;
  endsequence
  sequence brake_set;
    !drive.brake_release && drive.brake_apply;
  endsequence
  a_status_first: assert property (
    $rose(servo_enabled_status) |-> accept_late) else $error("accept not one cycle late");
  a_brake_valid: assert property (
    drive.brake_release ^ drive.brake_apply) else $error("brake lines not complementary");
  a_decel_end: assert property (
    $fell(stopping) |-> ##[0:1] brake_set) else $error("brake not set after decel");
  a_power_torque: assert property (
    stopping && $past(stopping) && drive.motor_power |-> drive.reverse_torque)
    else $error("power on without reverse torque");
  a_torque_idle: assert property (
    !stopping && !$past(stopping) |-> torque_limit == 16'h0) else $error("torque outside stop");
  a_off_unpowered: assert property (
    !servo_enabled_status && !stopping && !$past(stopping) |-> !drive.motor_power)
    else $error("power on while stopped");
  a_ppr_gear: assert property (
    gear.from_ppr |-> gear.num == ENC_COUNTS) else $error("ppr gear numerator wrong");
  a_too_low_ppr: assert property (
    ppr_too_low |-> ##[0:1] gear.from_ppr) else $error("low flag without ppr gearing");
  a_stop_entry: assert property (
    $fell(servo_enabled_status) |-> stopping) else $error("left run without decel");
endmodule : ssgr_assertions
bind ssgr_top ssgr_assertions #(.ENC_COUNTS(ENC_COUNTS)) u_chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .servo_enabled_status(servo_enabled_status), .cmd_accept(cmd_accept),
  .stopping(stopping), .drive(drive), .torque_limit(torque_limit), .gear(gear),
  .ppr_too_low(ppr_too_low));

// >>> dv/ssgr_master_model.sv
// Fieldbus master model: turns a bench request into a one-cycle config write.
// Assumes requests last one cycle and share clk_sys.
`timescale 1ns/1ps
module ssgr_master_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic [3:0] req_sel,
  input wire logic [31:0] req_data,
  output logic cfg_wr,
  output logic [3:0] cfg_sel,
  output logic [31:0] cfg_wdata
);
  // Idle lines toggle so a stale word can never pass for a fresh one
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_wr <= 1'b0;
      cfg_sel <= 4'h0;
      cfg_wdata <= 32'h0;
    end else begin
      cfg_wr <= req;
      cfg_sel <= req ? req_sel : ~cfg_sel;
      cfg_wdata <= req ? req_data : ~cfg_wdata;
    end
  end
endmodule : ssgr_master_model

// >>> dv/ssgr_tb_top.sv
// Bench for ssgr_top: config table, gearing, disable and alarm stops.
// Assumes the master model delays each request by one cycle.
`timescale 1ns/1ps
module ssgr_tb_top;
  import ssgr_pkg::*;
  typedef struct packed {logic w; logic [3:0] sel; logic [31:0] d; logic [31:0] e;} ssgr_row_t;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic enable_req = 1'b0;
  logic alarm_in = 1'b0;
  logic restart = 1'b0;
  logic signed [31:0] motor_velocity = 32'sh3e8;
  logic req = 1'b0;
  logic [3:0] req_sel = 4'h0;
  logic [31:0] req_data = 32'h0;
  logic [3:0] cfg_rd_sel = 4'h0;
  logic cfg_wr, servo_enabled_status, cmd_accept, stopping, ppr_too_low;
  logic [3:0] cfg_sel;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [15:0] torque_limit;
  ssgr_drive_t drive;
  ssgr_gear_t gear;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  logic [4:0] dec [3] = '{5'h1a, 5'h02, 5'h06};
  logic [4:0] post [3] = '{5'h01, 5'h05, 5'h01};
  ssgr_row_t rows [15] = '{'{0, 2, 0, 1}, '{0, 3, 0, 1}, '{0, 4, 0, 32'h2710}, '{0, 0, 0, 0},
    '{0, 1, 0, 32'h800000}, '{1, 2, 5, 5}, '{1, 2, 0, 5}, '{1, 3, 7, 7},
    '{1, 4, 32'h80000000, 32'h2710}, '{1, 0, 32'h800001, 0}, '{1, 1, 5, 32'h800000},
    '{1, 4'hb, 1, 0}, '{1, 7, 32'h55, 32'h55}, '{1, 9, 32'h64, 32'h64}, '{1, 8, 32'h64, 32'h64}};
  always #10 clk_sys = ~clk_sys;
  ssgr_master_model u_master (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req),
    .req_sel(req_sel), .req_data(req_data), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
    .cfg_wdata(cfg_wdata));
  ssgr_top #(.MS_CYCLES(10)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .enable_req(enable_req), .alarm_in(alarm_in), .restart(restart),
    .motor_velocity(motor_velocity), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
    .cfg_wdata(cfg_wdata), .cfg_rd_sel(cfg_rd_sel), .cfg_rdata(cfg_rdata),
    .servo_enabled_status(servo_enabled_status), .cmd_accept(cmd_accept),
    .stopping(stopping), .drive(drive), .torque_limit(torque_limit), .gear(gear),
    .ppr_too_low(ppr_too_low));
  task automatic finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_sys);
    req <= 1'b1;
    req_sel <= s;
    req_data <= d;
    @(posedge clk_sys);
    req <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] s, input logic [31:0] e);
    @(posedge clk_sys);
    cfg_rd_sel <= s;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(cfg_rdata, e);
  endtask : rd
  // Restart pulse copies the pending ppr value into use
  task automatic pr(input logic [65:0] e);
    @(posedge clk_sys);
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({gear, ppr_too_low}, e);
  endtask : pr
  task automatic wait_on(input logic which, input logic lvl);
    for (n = 0; n < 300 && (which ? stopping : servo_enabled_status) !== lvl; n++)
      @(negedge clk_sys);
    if (n == 300) begin
      num_errors++;
      finish_test();
    end
  endtask : wait_on
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    chk(drive, 5'h01);
    pr({32'h800000, 32'h2710, 2'b00});
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].sel, rows[i].d);
      rd(rows[i].sel, rows[i].e);
    end
    wr(4, 32'h800000);
    pr({32'h5, 32'h800000, 2'b00});
    wr(0, 32'd2000);
    pr({32'h800000, 32'd2000, 2'b10});
    wr(0, 32'd1000);
    pr({32'h800000, 32'd1000, 2'b11});
    wr(0, 32'd0);
    pr({32'h5, 32'h800000, 2'b00});
    for (logic [1:0] m = 0; m < 3; m++) begin
      wr(5, {28'h0, m, m});
      motor_velocity <= 32'sd1000;
      enable_req <= 1'b1;
      wait_on(0, 1);
      chk(cmd_accept, 0);
      @(negedge clk_sys);
      chk(cmd_accept, 1);
      @(posedge clk_sys);
      enable_req <= 1'b0;
      wait_on(1, 1);
      chk({drive, torque_limit}, {dec[m], m == 0 ? 16'h55 : 16'h0});
      @(posedge clk_sys);
      motor_velocity <= -32'sd50;
      wait_on(1, 0);
      @(negedge clk_sys);
      chk(drive, post[m]);
    end
    wr(6, 32'h5);
    wr(8, 32'h2);
    wr(5, 32'h0);
    motor_velocity <= 32'sd1000;
    enable_req <= 1'b1;
    wait_on(0, 1);
    @(posedge clk_sys);
    alarm_in <= 1'b1;
    wait_on(1, 1);
    chk(drive, 5'h02);
    wait_on(1, 0);
    chk(n >= 19 && n <= 23, 1);
    @(negedge clk_sys);
    chk(drive, 5'h05);
    rd(4'ha, 32'h57);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    chk(drive, 5'h01);
    rd(4'h2, 32'h1);
    finish_test();
  end
endmodule : ssgr_tb_top
